// [pkg/imt_pkg.sv]
// Package for the I2C master transmit engine: register map and timing
package imt_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_BUFFER = 8'h00; // Transmit buffer (write)
	localparam logic [7:0] ADDR_CONTROL = 8'h04; // Start/stop/restart requests
	localparam logic [7:0] ADDR_STATUS = 8'h08; // Flags and state
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C; // Sticky events, W1C
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10; // Interrupt mask
	localparam logic [7:0] ADDR_BAUD = 8'h14; // Baud rollover reload
	// Control bit positions
	localparam int CTL_START = 0; // start_request_bit
	localparam int CTL_STOP = 1; // stop_request_bit
	localparam int CTL_RESTART = 2; // restart_request_bit
	// Status bit positions
	localparam int ST_BF = 0; // buffer_full_flag
	localparam int ST_ACK = 1; // ack_status_bit
	localparam int ST_WRITE_COLLISION_FLAG = 2; // write_collision_flag
	localparam int ST_BUSY = 3; // Engine active
	// Event bit positions in the interrupt status register
	localparam int EV_SIF = 0; // serial_irq_flag
	localparam int EV_WRITE_COLLISION_FLAG = 1; // Write collision event
	localparam int EV_NACK = 2; // Not acknowledged event
	localparam int EV_W = 3; // Event vector width
	// Reset values
	localparam logic [15:0] BAUD_RESET = 16'h0018; // Rollover count
	localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
	// Start hold time in ns and derived cycles at 10 MHz
	localparam int CLK_NS = 100;
	localparam int START_HOLD_NS = 4000;
	localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_NS - 1) / CLK_NS;
	// Engine phases
	typedef enum logic [2:0] {
		IMT_IDLE, IMT_START, IMT_HOLD, IMT_LOW, IMT_HIGH, IMT_RS_UP,
		IMT_STOP_LOW, IMT_STOP_HIGH
	} imt_phase_t;
endpackage : imt_pkg

// [tb/imt_master_tx_chk.sv]
// Port checker for the I2C master transmit engine
`timescale 1ns/100ps
`default_nettype none
module imt_chk (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic scl_out,
	input wire logic scl_oe_out,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic irq_out
);
	localparam logic [15:0] HOLD = 16'(imt_pkg::START_HOLD_CYC - 1);
	logic wr; // A register write lands at this edge
	logic [15:0] half, hc; // Half-bit length; released SCL run
	logic [3:0] bc; // SCL rises since the last bus condition or ninth rise
	logic [2:0] msk; // Shadow of the interrupt mask
	logic park, sda_q, scl_q; // Idle between bytes; last enables
	assign wr = psel_in && penable_in && pwrite_in;
	//////////////////////////////////////////////////////////////////////////
	// Shadow state; SDA moving under a released SCL marks a condition
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{hc, bc, msk, park, sda_q, scl_q} <= '0;
			half <= imt_pkg::BAUD_RESET + 16'h0001;
		end else begin
			{sda_q, scl_q} <= {sda_oe_out, scl_oe_out};
			if (wr && paddr_in == imt_pkg::ADDR_BAUD)
				half <= pwdata_in[15:0] + 16'h0001;
			if (wr && paddr_in == imt_pkg::ADDR_IRQ_MASK)
				msk <= pwdata_in[2:0];
			hc <= (scl_oe_out || sda_oe_out != sda_q) ? '0 : hc + 16'h0001;
			if (!scl_oe_out && sda_oe_out != sda_q)
				bc <= '0;
			else if (scl_q && !scl_oe_out)
				bc <= (bc == 4'h8) ? '0 : bc + 4'h1;
			// A buffer or control write wakes the engine
			if (wr && paddr_in <= imt_pkg::ADDR_CONTROL)
				park <= 1'b0;
			else if (!scl_q && scl_oe_out && bc == 4'h0)
				park <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);
	a_open_drain: assert property (!scl_out && !sda_out)
		else $error("pin driven high");
	a_scl_high: assert property ($rose(scl_oe_out) |->
		hc == half || hc >= HOLD) else $error("SCL high time wrong");
	a_start_hold: assert property ($rose(scl_oe_out) &&
		sda_oe_out && bc == 4'h0 |-> hc >= HOLD) else $error("start short");
	a_sda_hold: assert property ($rose(scl_oe_out) |->
		$stable(sda_oe_out)) else $error("SDA moved at SCL fall");
	a_ack_free: assert property ($fell(scl_oe_out) &&
		bc == 4'h8 |-> !sda_oe_out) else $error("SDA held in ack bit");
	a_parked_low: assert property (park |->
		scl_oe_out && $stable(sda_oe_out)) else $error("idle bus moved");
	a_byte_begins: assert property (wr && park &&
		paddr_in == imt_pkg::ADDR_BUFFER |-> ##[1:80] !scl_oe_out)
		else $error("byte never started");
	a_irq_masked: assert property (msk == 3'h0 &&
		$past(msk) == 3'h0 |-> !irq_out) else $error("masked irq seen");
endmodule // imt_chk
`default_nettype wire

// [tb/imt_slave.sv]
// Behavioural I2C slave: takes one byte and answers the ninth bit
`timescale 1ns/100ps
`default_nettype none
module imt_slave (
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic ack_en_in,
	output logic sda_oe_out,
	output logic [7:0] byte_out
);
	int cnt = 0; // SCL falls since the last start or the ninth fall
	logic [7:0] sh = 8'h00; // Bits taken while SCL is high
	initial sda_oe_out = 1'b0;
	initial byte_out = 8'h00;
	//////////////////////////////////////////////////////////////////////////
	// SDA falling under a high SCL is a start; the next fall ends it
	always @(negedge sda_in)
		if (scl_in)
			cnt = -1;
	// Bits are sampled on the rising SCL edge, MSB first
	always @(posedge scl_in)
		if (cnt < 8)
			sh = {sh[6:0], sda_in};
	// Ack pulls SDA for the whole ninth bit time, then lets go
	always @(negedge scl_in) begin
		cnt = cnt + 1;
		if (cnt == 8) begin
			byte_out = sh;
			sda_oe_out = ack_en_in;
		end else if (cnt == 9) begin
			sda_oe_out = 1'b0;
			cnt = 0;
		end
	end
endmodule // imt_slave
`default_nettype wire

// [tb/tb_top.sv]
// Bench top: APB driver, slave model and transfer scenarios
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk_sys_in, nrst_in, psel_in, penable_in, pwrite_in, err;
	logic [7:0] paddr_in, slv_byte;
	logic [31:0] pwdata_in, prdata_out, r; // r: last read word
	logic pready_out, pslverr_out, scl_out, scl_oe_out, sda_out;
	logic sda_oe_out, irq_out, ack_en, slv_oe, scl_line, sda_line;
	logic [7:0] dat [2] = '{8'h3C, 8'hC3}; // Acked, then refused
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	// Pull-ups: a line is low only while some party pulls it
	assign scl_line = !scl_oe_out;
	assign sda_line = !(sda_oe_out || slv_oe);
	imt_master_tx DUT (.clk_sys_in, .nrst_in, .psel_in, .penable_in,
		.pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
		.pslverr_out, .scl_in(scl_line), .scl_out, .scl_oe_out,
		.sda_in(sda_line), .sda_out, .sda_oe_out, .irq_out);
	imt_slave slave (.scl_in(scl_line), .sda_in(sda_line),
		.ack_en_in(ack_en), .sda_oe_out(slv_oe), .byte_out(slv_byte));
	//////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = !clk_sys_in;
	end
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		do
			@(posedge clk_sys_in);
		while (pready_out !== 1'b1);
		r = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic fld(input logic [7:0] a, input int b, input logic e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(32'(r[b]), 32'(e));
	endtask
	// Waits for completion; the interrupt is a level
	task automatic wait_irq();
		repeat (3000)
			if (irq_out !== 1'b1)
				@(posedge clk_sys_in);
		chk(32'(irq_out), 32'h0000_0001);
	endtask
	task automatic clr();
		xfer(1'b1, imt_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
		repeat (2) @(posedge clk_sys_in);
		chk(32'(irq_out), 32'h0000_0000);
	endtask
	initial begin
		{psel_in, penable_in, pwrite_in, nrst_in, ack_en} = 5'h01;
		paddr_in = 8'h00;
		pwdata_in = 32'h0000_0000;
		repeat (4) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		// Reset values and an unmapped address
		xfer(1'b0, imt_pkg::ADDR_BAUD, 32'h0000_0000);
		chk(r, 32'(imt_pkg::BAUD_RESET));
		xfer(1'b0, 8'h40, 32'h0000_0000);
		chk({r[30:0], err}, 32'h0000_0001);
		xfer(1'b1, imt_pkg::ADDR_BAUD, 32'h0000_0003); // Half bit 4 cycles
		xfer(1'b1, imt_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		xfer(1'b1, imt_pkg::ADDR_CONTROL, 32'h0000_0001);
		wait_irq();
		fld(imt_pkg::ADDR_IRQ_STAT, imt_pkg::EV_SIF, 1'b1);
		clr();
		// Address byte, then a refused write while it shifts
		xfer(1'b1, imt_pkg::ADDR_BUFFER, 32'h0000_00A4);
		fld(imt_pkg::ADDR_STATUS, imt_pkg::ST_BF, 1'b1);
		fld(imt_pkg::ADDR_STATUS, imt_pkg::ST_BUSY, 1'b1);
		xfer(1'b1, imt_pkg::ADDR_BUFFER, 32'h0000_005B);
		fld(imt_pkg::ADDR_STATUS, imt_pkg::ST_WRITE_COLLISION_FLAG, 1'b1);
		fld(imt_pkg::ADDR_IRQ_STAT, imt_pkg::EV_WRITE_COLLISION_FLAG, 1'b1);
		xfer(1'b0, imt_pkg::ADDR_BUFFER, 32'h0000_0000);
		chk(r, 32'h0000_00A4);
		chk(32'(irq_out), 32'h0000_0000);
		wait_irq();
		chk(32'(slv_byte), 32'h0000_00A4);
		fld(imt_pkg::ADDR_STATUS, imt_pkg::ST_BF, 1'b0);
		fld(imt_pkg::ADDR_STATUS, imt_pkg::ST_ACK, 1'b0);
		xfer(1'b1, imt_pkg::ADDR_STATUS, 32'h0000_0004);
		fld(imt_pkg::ADDR_STATUS, imt_pkg::ST_WRITE_COLLISION_FLAG, 1'b0);
		clr();
		// Data bytes: first acknowledged, second refused
		for (int i = 0; i < 2; i++) begin
			ack_en <= (i == 0);
			xfer(1'b1, imt_pkg::ADDR_BUFFER, 32'(dat[i]));
			wait_irq();
			chk(32'(slv_byte), 32'(dat[i]));
			fld(imt_pkg::ADDR_STATUS, imt_pkg::ST_ACK, i == 1);
			fld(imt_pkg::ADDR_IRQ_STAT, imt_pkg::EV_NACK, i == 1);
			clr();
		end
		xfer(1'b1, imt_pkg::ADDR_CONTROL, 32'h0000_0004);
		wait_irq();
		clr();
		xfer(1'b1, imt_pkg::ADDR_CONTROL, 32'h0000_0002);
		wait_irq();
		chk(32'({scl_line, sda_line}), 32'h0000_0003);
		fld(imt_pkg::ADDR_STATUS, imt_pkg::ST_BUSY, 1'b0);
		// Masking hides the level but keeps the sticky bit
		xfer(1'b1, imt_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk_sys_in);
		chk(32'(irq_out), 32'h0000_0000);
		fld(imt_pkg::ADDR_IRQ_STAT, imt_pkg::EV_SIF, 1'b1);
		clr();
		wrap_up();
	end
endmodule // tb_top
bind imt_master_tx imt_chk chk (.clk_sys_in, .nrst_in, .psel_in,
	.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .scl_out, .scl_oe_out,
	.sda_out, .sda_oe_out, .irq_out);
`default_nettype wire

// [verilog/imt_master_tx.sv]
// I2C master transmit engine with APB register access
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RL1] Buffer write sets full flag, starts transfer
// [RL2] SDA changes with SCL low; each half one rollover
// [RL3] SDA held through SCL high and past fall
// [RL4] After eighth bit clear full flag, release SDA
// [RL5] Ninth clock samples SDA into ack status
// [RL6] After ninth clock raise irq, park SCL low
// [RL7] Address: seven bits plus direction, MSB first
// [RL8] Buffer write while shifting sets collision, ignored
// [RL9] Software clears collision before next transmission
// [RL10] Start request makes Start, then irq flag
// [RL11] Software clears irq flag after each event
// [RL12] Start hold time before any bus operation
// [RL13] Stop or restart request, then irq flag
// [RL14] Slave acknowledges in ninth bit time
// [RL15] SDA and SCL driven open drain only
//////////////////////////////////////////////////////////////////////////////
module imt_master_tx (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic irq_out
);
	//////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		imt_pkg::imt_phase_t phase; // Engine phase
		logic [15:0] cnt; // Rollover / hold counter
		logic [15:0] baud; // Rollover reload value
		logic [7:0] buffer; // transmit_buffer
		logic [7:0] shift; // shift_register
		logic [3:0] bitn; // Bit clock number 0..8
		logic bf; // buffer_full_flag
		logic ack; // ack_status_bit
		logic write_collision_flag; // write_collision_flag
		logic scl_low; // Pull SCL low
		logic sda_low; // Pull SDA low
		logic [imt_pkg::EV_W-1:0] ev; // Sticky events
		logic [imt_pkg::EV_W-1:0] mask; // Interrupt mask
		logic [31:0] rdata; // Registered read data
	} imt_state_t;

	imt_state_t cur;
	imt_state_t next_cur;
	logic wr_acc; // Write access phase
	logic rd_acc; // Read setup phase
	logic mapped; // Address decodes
	logic [imt_pkg::EV_W-1:0] set_ev; // Events this cycle

	// Zero-extend a byte to the bus width
	function automatic logic [31:0] imt_word(input logic [7:0] b);
		imt_word = {24'h0000_00, b};
	endfunction

	// Engine owns the bus; buffer and control writes are refused then
	function automatic logic imt_busy(input imt_pkg::imt_phase_t ph);
		imt_busy = (ph != imt_pkg::IMT_IDLE);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Bus decode; zero wait states, unmapped gives slave error
	// pready is tied high, so no access ever stalls the bus
	always_comb begin
		mapped = (paddr_in == imt_pkg::ADDR_BUFFER) ||
			(paddr_in == imt_pkg::ADDR_CONTROL) ||
			(paddr_in == imt_pkg::ADDR_STATUS) ||
			(paddr_in == imt_pkg::ADDR_IRQ_STAT) ||
			(paddr_in == imt_pkg::ADDR_IRQ_MASK) ||
			(paddr_in == imt_pkg::ADDR_BAUD);
		wr_acc = psel_in && penable_in && pwrite_in;
		rd_acc = psel_in && !penable_in && !pwrite_in;
	end

	//////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		next_cur = cur;
		set_ev = '0;
		// Read data is captured in setup so it is ready in access
		if (rd_acc) begin
			unique case (paddr_in)
				imt_pkg::ADDR_BUFFER: next_cur.rdata = imt_word(cur.buffer);
				imt_pkg::ADDR_STATUS: begin
					next_cur.rdata = '0;
					next_cur.rdata[imt_pkg::ST_BF] = cur.bf;
					next_cur.rdata[imt_pkg::ST_ACK] = cur.ack;
					next_cur.rdata[imt_pkg::ST_WRITE_COLLISION_FLAG] = cur.write_collision_flag;
					next_cur.rdata[imt_pkg::ST_BUSY] =
						imt_busy(cur.phase);
				end
				imt_pkg::ADDR_IRQ_STAT: next_cur.rdata = {29'h0, cur.ev};
				imt_pkg::ADDR_IRQ_MASK: next_cur.rdata = {29'h0, cur.mask};
				imt_pkg::ADDR_BAUD: next_cur.rdata = {16'h0000, cur.baud};
				default: next_cur.rdata = '0;
			endcase
		end
		// Countdown runs in every timed phase
		if (cur.cnt != 16'h0000) begin
			next_cur.cnt = cur.cnt - 16'h0001;
		end
		unique case (cur.phase)
			imt_pkg::IMT_IDLE: begin
				// SCL parked low after a byte, SDA unchanged [RL6]
			end
			imt_pkg::IMT_START: begin
				// SDA falls while SCL is high: Start condition [RL10]
				next_cur.sda_low = 1'b1;
				next_cur.scl_low = 1'b0;
				next_cur.cnt = 16'(imt_pkg::START_HOLD_CYC);
				next_cur.phase = imt_pkg::IMT_HOLD;
			end
			imt_pkg::IMT_HOLD: begin
				// Hold time elapses before anything else [RL12]
				// It also keeps the first bit clear of the Start
				if (cur.cnt == 16'h0000) begin
					next_cur.scl_low = 1'b1;
					next_cur.phase = imt_pkg::IMT_IDLE;
					set_ev[imt_pkg::EV_SIF] = 1'b1; // [RL10]
				end
			end
			imt_pkg::IMT_LOW: begin
				// Bit changes only while SCL low [RL2]
				// SDA moves a cycle after SCL falls: that cycle is hold time
				if (cur.cnt == cur.baud) begin
					if (cur.bitn == 4'h8) begin
						next_cur.sda_low = 1'b0; // Release for ACK [RL4]
					end else begin
						next_cur.sda_low = !cur.shift[7]; // MSB first [RL7]
					end
				end
				if (cur.cnt == 16'h0000) begin
					next_cur.scl_low = 1'b0; // Release SCL [RL2]
					next_cur.cnt = cur.baud;
					next_cur.phase = imt_pkg::IMT_HIGH;
				end
			end
			imt_pkg::IMT_HIGH: begin
				// SDA untouched during high half [RL3]
				if (cur.cnt == 16'h0000) begin
					next_cur.scl_low = 1'b1;
					// SDA holds one clock cycle after fall [RL3]
					next_cur.cnt = cur.baud;
					if (cur.bitn == 4'h8) begin
						// Taken on the last high cycle, before SCL falls,
						// while the slave still drives its acknowledge
						// Ninth clock: ACK low clears, high sets [RL5]
						next_cur.ack = sda_in;
						set_ev[imt_pkg::EV_NACK] = sda_in;
						set_ev[imt_pkg::EV_SIF] = 1'b1; // [RL6]
						next_cur.cnt = 16'h0000;
						next_cur.phase = imt_pkg::IMT_IDLE;
					end else begin
						next_cur.shift = {cur.shift[6:0], 1'b0};
						next_cur.bitn = cur.bitn + 4'h1;
						// Eighth fall empties the buffer [RL4]
						if (cur.bitn == 4'h7) begin
							next_cur.bf = 1'b0;
						end
						next_cur.phase = imt_pkg::IMT_LOW;
					end
				end
			end
			imt_pkg::IMT_RS_UP: begin
				// Release SDA then SCL, then repeated Start [RL13]
				// SDA must rise while SCL is low, or the bus would see a Stop
				next_cur.sda_low = 1'b0;
				if (cur.cnt == 16'h0000) begin
					if (cur.scl_low) begin
						next_cur.scl_low = 1'b0;
						next_cur.cnt = cur.baud;
					end else begin
						next_cur.phase = imt_pkg::IMT_START;
					end
				end
			end
			imt_pkg::IMT_STOP_LOW: begin
				// Pull SDA low with SCL low, then release SCL [RL13]
				next_cur.sda_low = 1'b1;
				if (cur.cnt == 16'h0000) begin
					next_cur.scl_low = 1'b0;
					next_cur.cnt = cur.baud;
					next_cur.phase = imt_pkg::IMT_STOP_HIGH;
				end
			end
			imt_pkg::IMT_STOP_HIGH: begin
				// SDA rises while SCL high: Stop [RL13]
				if (cur.cnt == 16'h0000) begin
					next_cur.sda_low = 1'b0;
					next_cur.phase = imt_pkg::IMT_IDLE;
					set_ev[imt_pkg::EV_SIF] = 1'b1; // [RL13]
				end
			end
		endcase
		// Register writes
		if (wr_acc) begin
			unique case (paddr_in)
				imt_pkg::ADDR_BUFFER: begin
					// Busy covers the Start hold too, so an early address
					// cannot cut the hold short
					if (imt_busy(cur.phase)) begin
						// Busy: flag collision, drop data [RL8]
						next_cur.write_collision_flag = 1'b1;
						set_ev[imt_pkg::EV_WRITE_COLLISION_FLAG] = 1'b1;
					end else begin
						// Load and start the baud generator [RL1]
						next_cur.buffer = pwdata_in[7:0];
						next_cur.shift = pwdata_in[7:0];
						next_cur.bf = 1'b1;
						next_cur.bitn = 4'h0;
						next_cur.scl_low = 1'b1;
						next_cur.cnt = cur.baud;
						next_cur.phase = imt_pkg::IMT_LOW;
					end
				end
				imt_pkg::ADDR_CONTROL: begin
					// Requests are ignored while the engine is busy
					// One request per write: start, then stop, then restart
					if (!imt_busy(cur.phase)) begin
						if (pwdata_in[imt_pkg::CTL_START]) begin
							next_cur.phase = imt_pkg::IMT_START;
						end else if (pwdata_in[imt_pkg::CTL_STOP]) begin
							next_cur.scl_low = 1'b1;
							next_cur.cnt = cur.baud;
							next_cur.phase = imt_pkg::IMT_STOP_LOW;
						end else if (pwdata_in[imt_pkg::CTL_RESTART]) begin
							next_cur.scl_low = 1'b1;
							next_cur.cnt = cur.baud;
							next_cur.phase = imt_pkg::IMT_RS_UP;
						end
					end
				end
				imt_pkg::ADDR_STATUS: begin
					// Software clears collision by writing one [RL9]
					if (pwdata_in[imt_pkg::ST_WRITE_COLLISION_FLAG]) begin
						next_cur.write_collision_flag = 1'b0;
					end
				end
				imt_pkg::ADDR_IRQ_STAT: begin
					// Write one to clear [RL11]
					next_cur.ev = cur.ev & ~pwdata_in[imt_pkg::EV_W-1:0];
				end
				imt_pkg::ADDR_IRQ_MASK: begin
					next_cur.mask = pwdata_in[imt_pkg::EV_W-1:0];
				end
				imt_pkg::ADDR_BAUD: begin
					next_cur.baud = pwdata_in[15:0];
				end
				default: begin
				end
			endcase
		end
		// A new event wins over a clear in the same cycle
		next_cur.ev = next_cur.ev | set_ev;
		if (set_ev[imt_pkg::EV_WRITE_COLLISION_FLAG]) begin
			next_cur.write_collision_flag = 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// State register
	// Reset releases both lines, so no false condition appears
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cur <= '0;
			cur.phase <= imt_pkg::IMT_IDLE;
			cur.baud <= imt_pkg::BAUD_RESET;
			cur.mask <= imt_pkg::MASK_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs; lines only ever pulled low, high is released [RL15]
	// scl_in is not read: a slave that stretches SCL is not waited for
	always_comb begin
		prdata_out = cur.rdata;
		pready_out = 1'b1;
		pslverr_out = psel_in && penable_in && !mapped;
		scl_out = 1'b0;
		scl_oe_out = cur.scl_low; // [RL15]
		sda_out = 1'b0;
		sda_oe_out = cur.sda_low; // [RL15]
		irq_out = |(cur.ev & cur.mask);
	end
endmodule // imt_master_tx
`default_nettype wire
